/* hw/acr_lane_state.sv */
// acr_lane_state: power-down and output reset bits held for one channel
`timescale 1ns/1ns
`default_nettype none
module acr_lane_state
  import acr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_mask,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] state_q
);
  logic [7:0] state_d;

  always_comb begin
    state_d = state_q;
    if (wr_en) begin
      state_d = wr_data & wr_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= RST_CHAN_STATE;
    end else begin
      state_q <= state_d;
    end
  end
endmodule
`default_nettype wire

/* hw/acr_pkg.sv */
// acr_pkg: register offsets, reset values and field positions of the output configuration bank
package acr_pkg;
  localparam logic [9:0] ADDR_CHAN_INDEX   = 10'h005;
  localparam logic [9:0] ADDR_CLK_DIVIDE   = 10'h00b;
  localparam logic [9:0] ADDR_OUT_PHASE    = 10'h016;
  localparam logic [9:0] ADDR_REF_RANGE    = 10'h018;
  localparam logic [9:0] ADDR_PATT_A_LO    = 10'h019;
  localparam logic [9:0] ADDR_PATT_A_HI    = 10'h01a;
  localparam logic [9:0] ADDR_PATT_B_LO    = 10'h01b;
  localparam logic [9:0] ADDR_PATT_B_HI    = 10'h01c;
  localparam logic [9:0] ADDR_FRAMING      = 10'h021;
  localparam logic [9:0] ADDR_CHAN_STATE   = 10'h022;
  localparam logic [9:0] ADDR_TRANSFER     = 10'h0ff;
  localparam logic [9:0] ADDR_SPEED_OVR    = 10'h100;
  localparam logic [9:0] ADDR_IO_PULLDOWN  = 10'h101;
  localparam logic [9:0] ADDR_CM_GEN       = 10'h102;
  localparam logic [9:0] ADDR_ALIGN        = 10'h109;

  localparam logic [7:0] RST_CHAN_INDEX  = 8'h3f;
  localparam logic [7:0] RST_OUT_PHASE   = 8'h03;
  localparam logic [7:0] RST_REF_RANGE   = 8'h04;
  localparam logic [7:0] RST_PATT        = 8'h00;
  localparam logic [7:0] RST_FRAMING     = 8'h32;
  localparam logic [7:0] RST_CHAN_STATE  = 8'h00;
  localparam logic [7:0] RST_SPEED_OVR   = 8'h00;
  localparam logic [7:0] RST_IO_PULLDOWN = 8'h00;
  localparam logic [7:0] RST_CM_GEN      = 8'h00;
  localparam logic [7:0] RST_ALIGN       = 8'h00;

  localparam logic [7:0] MASK_OUT_PHASE   = 8'h7f;
  localparam logic [7:0] MASK_REF_RANGE   = 8'h07;
  localparam logic [7:0] MASK_FRAMING     = 8'hf7;
  localparam logic [7:0] MASK_CHAN_STATE  = 8'h03;
  localparam logic [7:0] MASK_SPEED_OVR   = 8'h77;
  localparam logic [7:0] MASK_IO_PULLDOWN = 8'h01;
  localparam logic [7:0] MASK_CM_GEN      = 8'h08;
  localparam logic [7:0] MASK_ALIGN       = 8'h03;
  localparam logic [7:0] MASK_CHAN_INDEX  = 8'h3f;

  localparam int IN_PHASE_LSB   = 4;
  localparam int IN_PHASE_W     = 3;
  localparam int OUT_PHASE_LSB  = 0;
  localparam int OUT_PHASE_W    = 4;
  localparam logic [3:0] OUT_PHASE_MAX = 4'hb;
  localparam int PWRDN_BIT      = 0;
  localparam int ORST_BIT       = 1;
  localparam int TRANSFER_BIT   = 0;
  localparam int DATA_SEL_W     = 4;
  localparam int CLK_SEL_LSB    = 4;
  localparam int CLK_SEL_W      = 2;
  localparam int NUM_LANES      = 6;
  localparam logic [7:0] CLK_LANE_STATE_MASK = 8'h01;
endpackage

/* hw/acr_regs.sv */
// acr_regs: output configuration register bank behind the serial port register access
`timescale 1ns/1ns
`default_nettype none
module acr_regs
  import acr_pkg::*;
#(
  parameter int LANES = NUM_LANES
)(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [9:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             clk_div_active,
  input  wire logic [2:0]       clk_div_ratio,
  output logic      [7:0]       reg_rdata,
  output logic      [2:0]       in_clk_delay,
  output logic      [3:0]       data_clock_out_phase,
  output logic                  data_clock_out_phase_ok,
  output logic      [2:0]       ref_range_code,
  output logic      [15:0]      test_pattern_a,
  output logic      [15:0]      test_pattern_b,
  output logic      [7:0]       framing_ctrl,
  output logic      [LANES-1:0] lane_power_down,
  output logic      [LANES-1:0] lane_output_reset,
  output logic      [7:0]       speed_grade_active,
  output logic                  io_pulldown_off,
  output logic                  cm_gen_power_down,
  output logic      [1:0]       align_ctrl,
  output logic                  in_delay_illegal
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]       sel_q, sel_d;
  logic [7:0]       phase_q, phase_d;
  logic [7:0]       ref_q, ref_d;
  logic [7:0]       pa_lo_q, pa_lo_d;
  logic [7:0]       pa_hi_q, pa_hi_d;
  logic [7:0]       pb_lo_q, pb_lo_d;
  logic [7:0]       pb_hi_q, pb_hi_d;
  logic [7:0]       frm_q, frm_d;
  logic [7:0]       ovr_q, ovr_d;
  // committed copy, so a half-written grade never reaches the converter
  logic [7:0]       ovr_act_q, ovr_act_d;
  logic [7:0]       iopd_q, iopd_d;
  logic [7:0]       cm_q, cm_d;
  logic [7:0]       aln_q, aln_d;
  logic [7:0]       rdata_q, rdata_d;
  logic [7:0]       lane_q [LANES];
  logic [LANES-1:0] lane_sel;
  logic             state_wr;

  assign state_wr = reg_wr && (reg_addr == ADDR_CHAN_STATE);

  // ----------------------------------------------------------------
  // per-channel state
  // ----------------------------------------------------------------
  // channel targets
  assign lane_sel = sel_q[LANES-1:0];

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    acr_lane_state u_lane (
      .clk     (clk),
      .srst    (srst),
      .wr_en   (state_wr && lane_sel[g]),
      .wr_mask ((g >= DATA_SEL_W) ? CLK_LANE_STATE_MASK : MASK_CHAN_STATE),
      .wr_data (reg_wdata),
      .state_q (lane_q[g])
    );
    assign lane_power_down[g]   = lane_q[g][PWRDN_BIT];
    assign lane_output_reset[g] = lane_q[g][ORST_BIT];
  end

  // ----------------------------------------------------------------
  // global registers and read path
  // ----------------------------------------------------------------
  always_comb begin
    sel_d = sel_q;
    phase_d = phase_q;
    ref_d = ref_q;
    pa_lo_d = pa_lo_q;
    pa_hi_d = pa_hi_q;
    pb_lo_d = pb_lo_q;
    pb_hi_d = pb_hi_q;
    frm_d = frm_q;
    ovr_d = ovr_q;
    ovr_act_d = ovr_act_q;
    iopd_d = iopd_q;
    cm_d = cm_q;
    aln_d = aln_q;
    rdata_d = rdata_q;
    // reserved bits are masked on write, so they always read back as zero
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CHAN_INDEX:  sel_d   = reg_wdata & MASK_CHAN_INDEX;
        ADDR_OUT_PHASE:   phase_d = reg_wdata & MASK_OUT_PHASE;
        ADDR_REF_RANGE:   ref_d   = reg_wdata & MASK_REF_RANGE;
        ADDR_PATT_A_LO:   pa_lo_d = reg_wdata;
        ADDR_PATT_A_HI:   pa_hi_d = reg_wdata;
        ADDR_PATT_B_LO:   pb_lo_d = reg_wdata;
        ADDR_PATT_B_HI:   pb_hi_d = reg_wdata;
        ADDR_FRAMING:     frm_d   = reg_wdata & MASK_FRAMING;
        ADDR_SPEED_OVR:   ovr_d   = reg_wdata & MASK_SPEED_OVR;
        ADDR_IO_PULLDOWN: iopd_d  = reg_wdata & MASK_IO_PULLDOWN;
        ADDR_CM_GEN:      cm_d    = reg_wdata & MASK_CM_GEN;
        ADDR_ALIGN:       aln_d   = reg_wdata & MASK_ALIGN;
        ADDR_TRANSFER: begin
          // transfer stores nothing of its own, it only copies the working grade
          if (reg_wdata[TRANSFER_BIT]) begin
            ovr_act_d = ovr_q;
          end
        end
        default: ;
      endcase
    end
    // read data is registered, so it answers one cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CHAN_INDEX:  rdata_d = sel_q;
        ADDR_OUT_PHASE:   rdata_d = phase_q;
        ADDR_REF_RANGE:   rdata_d = ref_q;
        ADDR_PATT_A_LO:   rdata_d = pa_lo_q;
        ADDR_PATT_A_HI:   rdata_d = pa_hi_q;
        ADDR_PATT_B_LO:   rdata_d = pb_lo_q;
        ADDR_PATT_B_HI:   rdata_d = pb_hi_q;
        ADDR_FRAMING:     rdata_d = frm_q;
        // first selected lane answers; a mixed selection reads the lowest one
        ADDR_CHAN_STATE: begin
          rdata_d = 8'h00;
          for (int i = LANES - 1; i >= 0; i--) begin
            if (lane_sel[i]) begin
              rdata_d = lane_q[i];
            end
          end
        end
        ADDR_SPEED_OVR:   rdata_d = ovr_q;
        ADDR_IO_PULLDOWN: rdata_d = iopd_q;
        ADDR_CM_GEN:      rdata_d = cm_q;
        ADDR_ALIGN:       rdata_d = aln_q;
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_q <= RST_CHAN_INDEX;
      phase_q <= RST_OUT_PHASE;
      ref_q <= RST_REF_RANGE;
      pa_lo_q <= RST_PATT;
      pa_hi_q <= RST_PATT;
      pb_lo_q <= RST_PATT;
      pb_hi_q <= RST_PATT;
      frm_q <= RST_FRAMING;
      ovr_q <= RST_SPEED_OVR;
      ovr_act_q <= RST_SPEED_OVR;
      iopd_q <= RST_IO_PULLDOWN;
      cm_q <= RST_CM_GEN;
      aln_q <= RST_ALIGN;
      rdata_q <= 8'h00;
    end else begin
      sel_q <= sel_d;
      phase_q <= phase_d;
      ref_q <= ref_d;
      pa_lo_q <= pa_lo_d;
      pa_hi_q <= pa_hi_d;
      pb_lo_q <= pb_lo_d;
      pb_hi_q <= pb_hi_d;
      frm_q <= frm_d;
      ovr_q <= ovr_d;
      ovr_act_q <= ovr_act_d;
      iopd_q <= iopd_d;
      cm_q <= cm_d;
      aln_q <= aln_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign in_clk_delay = clk_div_active ? phase_q[IN_PHASE_LSB +: IN_PHASE_W] : 3'h0;
  // flag host misuse; device does not clamp it
  assign in_delay_illegal = phase_q[IN_PHASE_LSB +: IN_PHASE_W] > clk_div_ratio;
  // codes past the last 60 degree step are flagged, not clamped
  // output clock phase in 60 degree steps
  assign data_clock_out_phase    = phase_q[OUT_PHASE_LSB +: OUT_PHASE_W];
  assign data_clock_out_phase_ok = clk_div_active &&
                                   (phase_q[OUT_PHASE_LSB +: OUT_PHASE_W] <= OUT_PHASE_MAX);
  assign ref_range_code     = ref_q[2:0];
  assign test_pattern_a     = {pa_hi_q, pa_lo_q};
  assign test_pattern_b     = {pb_hi_q, pb_lo_q};
  assign framing_ctrl       = frm_q;
  assign speed_grade_active = ovr_act_q;
  assign io_pulldown_off    = iopd_q[0];
  assign cm_gen_power_down  = cm_q[3];
  assign align_ctrl         = aln_q[1:0];
endmodule
`default_nettype wire

/* sim/acr_host.sv */
// acr_host: serial-port host model issuing register writes and reads
`timescale 1ns/1ns
`default_nettype none
module acr_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [9:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
  end
  // one request per edge; commit and delay limits left to the caller
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released lines scrambled so stale values never look valid
    reg_addr = ~a;
    reg_wdata = ~d;
    if (!w) @(negedge clk);
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* sim/acr_properties.sv */
// acr_properties: timing checks on the output configuration register bank
`timescale 1ns/1ns
`default_nettype none
module acr_properties
  import acr_pkg::*;
#(
  parameter int LANES = NUM_LANES
)(
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             reg_wr,
  input wire logic [9:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             clk_div_active,
  input wire logic [2:0]       clk_div_ratio,
  input wire logic [2:0]       in_clk_delay,
  input wire logic [3:0]       data_clock_out_phase,
  input wire logic [LANES-1:0] lane_power_down,
  input wire logic [LANES-1:0] lane_output_reset,
  input wire logic [7:0]       speed_grade_active,
  input wire logic             io_pulldown_off,
  input wire logic             in_delay_illegal
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic w_ph;
  logic w_ln;
  logic w_cm;
  assign w_ph = reg_wr && reg_addr == ADDR_OUT_PHASE;
  assign w_ln = reg_wr && reg_addr == ADDR_CHAN_STATE;
  assign w_cm = reg_wr && reg_addr == ADDR_TRANSFER && reg_wdata[TRANSFER_BIT];
  property p_dly; w_ph ##1 clk_div_active |-> in_clk_delay == $past(reg_wdata[6:4]); endproperty
  property p_ph; w_ph |=> data_clock_out_phase == $past(reg_wdata[3:0]); endproperty
  property p_rst; $fell(srst) |-> data_clock_out_phase == 4'h3; endproperty
  property p_hold; !w_ln |=> $stable(lane_power_down) && $stable(lane_output_reset); endproperty
  property p_clk; lane_output_reset[LANES-1:DATA_SEL_W] == '0; endproperty
  property p_spd; !w_cm |=> $stable(speed_grade_active); endproperty
  property p_io;
    reg_wr && reg_addr == ADDR_IO_PULLDOWN |=> io_pulldown_off == $past(reg_wdata[0]);
  endproperty
  property p_bad; clk_div_active |-> in_delay_illegal == (in_clk_delay > clk_div_ratio); endproperty
  a_dly: assert property (p_dly) else $error("input delay wrong");
  a_ph: assert property (p_ph) else $error("phase code wrong");
  a_rst: assert property (p_rst) else $error("phase reset wrong");
  a_hold: assert property (p_hold) else $error("lane state moved");
  a_clk: assert property (p_clk) else $error("clock lane reset set");
  a_spd: assert property (p_spd) else $error("override early");
  a_io: assert property (p_io) else $error("pulldown late");
  a_bad: assert property (p_bad) else $error("delay flag wrong");
  c_cm: cover property (w_cm);
  c_bad: cover property (in_delay_illegal);
  c_lane: cover property (lane_power_down[LANES-1]);
endmodule
bind acr_regs acr_properties #(.LANES(LANES)) i_props (.clk, .srst, .reg_wr, .reg_addr,
  .reg_wdata, .clk_div_active, .clk_div_ratio, .in_clk_delay, .data_clock_out_phase,
  .lane_power_down, .lane_output_reset, .speed_grade_active, .io_pulldown_off, .in_delay_illegal);
`default_nettype wire

/* sim/acr_regs_test.sv */
// acr_regs_test: self-checking bench for the output configuration register bank
`timescale 1ns/1ns
`default_nettype none
module acr_regs_test
  import acr_pkg::*;
;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        clk_div_active = 1'b1;
  logic [2:0]  clk_div_ratio = 3'h3;
  logic        reg_wr, reg_rd, data_clock_out_phase_ok, io_pulldown_off;
  logic        cm_gen_power_down, in_delay_illegal;
  logic [9:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, framing_ctrl, speed_grade_active, q;
  logic [2:0]  in_clk_delay, ref_range_code;
  logic [3:0]  data_clock_out_phase;
  logic [15:0] test_pattern_a, test_pattern_b;
  logic [5:0]  lane_power_down, lane_output_reset;
  logic [1:0]  align_ctrl;
  int          num_errors = 0;
  int          comparisons = 0;
  always #50 clk = ~clk;
  acr_host i_host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  acr_regs #(.LANES(6)) i_dut (.clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .clk_div_active, .clk_div_ratio, .reg_rdata, .in_clk_delay, .data_clock_out_phase,
    .data_clock_out_phase_ok, .ref_range_code, .test_pattern_a, .test_pattern_b, .framing_ctrl,
    .lane_power_down, .lane_output_reset, .speed_grade_active, .io_pulldown_off,
    .cm_gen_power_down, .align_ctrl, .in_delay_illegal);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    i_host.xfer(1'b0, a, 8'h00, q);
    chk(16'(q), 16'(e));
  endtask
  task automatic final_report;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    logic [9:0] a [14] = '{10'h005, 10'h016, 10'h018, 10'h019, 10'h01a, 10'h01b, 10'h01c,
                           10'h021, 10'h022, 10'h100, 10'h101, 10'h102, 10'h109, 10'h3fe};
    logic [7:0] e [14] = '{8'h3f, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h32, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    wr(10'h3fe, 8'hff);
    for (int i = 0; i < 14; i++) begin
      rd(a[i], e[i]);
    end
    chk({framing_ctrl, 5'h00, ref_range_code}, 16'h3204);
  endtask
  task automatic t_phase;
    wr(ADDR_OUT_PHASE, 8'h2b);
    chk({data_clock_out_phase_ok, data_clock_out_phase, in_delay_illegal, in_clk_delay}, 16'h1b2);
    // host deliberately exceeds the divide ratio here
    wr(ADDR_OUT_PHASE, 8'hdc);
    chk({data_clock_out_phase_ok, data_clock_out_phase, in_delay_illegal, in_clk_delay}, 16'hcd);
    clk_div_active = 1'b0;
    rd(ADDR_OUT_PHASE, 8'h5c);
    chk({data_clock_out_phase_ok, in_clk_delay}, 16'h0);
    clk_div_active = 1'b1;
    wr(ADDR_REF_RANGE, 8'hff);
    wr(ADDR_FRAMING, 8'hff);
    chk({framing_ctrl, 5'h00, ref_range_code}, 16'hf707);
  endtask
  task automatic t_patt_lanes;
    wr(ADDR_PATT_A_LO, 8'h5a);
    wr(ADDR_PATT_A_HI, 8'ha5);
    wr(ADDR_PATT_B_LO, 8'h0f);
    wr(ADDR_PATT_B_HI, 8'hf0);
    chk(test_pattern_a ^ test_pattern_b, 16'h5555);
    chk(test_pattern_b, 16'hf00f);
    wr(ADDR_CHAN_INDEX, 8'h02);
    wr(ADDR_CHAN_STATE, 8'h03);
    chk({lane_output_reset, 2'b00, lane_power_down}, 16'h0202);
    wr(ADDR_CHAN_INDEX, 8'h30);
    wr(ADDR_CHAN_STATE, 8'h03);
    chk({lane_output_reset, 2'b00, lane_power_down}, 16'h0232);
    rd(ADDR_CHAN_STATE, 8'h01);
    wr(ADDR_ALIGN, 8'hff);
    chk(16'(align_ctrl), 16'h3);
  endtask
  task automatic t_speed;
    wr(ADDR_SPEED_OVR, 8'hff);
    wr(ADDR_IO_PULLDOWN, 8'h01);
    wr(ADDR_CM_GEN, 8'hff);
    chk({io_pulldown_off, cm_gen_power_down, speed_grade_active}, 16'h300);
    wr(ADDR_TRANSFER, 8'hfe);
    chk(16'(speed_grade_active), 16'h0);
    wr(ADDR_TRANSFER, 8'h01);
    chk(16'(speed_grade_active), 16'h77);
    wr(ADDR_SPEED_OVR, 8'h00);
    chk(16'(speed_grade_active), 16'h77);
    rd(ADDR_CM_GEN, 8'h08);
    // second reset in mid-run must restore the power-up values
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    rd(ADDR_OUT_PHASE, 8'h03);
    rd(ADDR_FRAMING, 8'h32);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_phase();
    t_patt_lanes();
    t_speed();
    final_report();
  end
  initial begin
    repeat (2000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
